// File: hw/mrf_params.svh
// constants for the receive filter, management and pause block
`ifndef MRF_PARAMS_SVH
`define MRF_PARAMS_SVH
// register offsets (byte addresses)
`define MRF_OFF_CTRL 12'h000
`define MRF_OFF_RX_STAT 12'h004
`define MRF_OFF_CAM_EN 12'h008
`define MRF_OFF_MD_CMD 12'h00C
`define MRF_OFF_MD_STAT 12'h010
`define MRF_OFF_CTL_TX 12'h014
`define MRF_OFF_CAM_BASE 12'h100
// field positions
`define MRF_CTRL_RX_EN 0
`define MRF_CTRL_SEND_PAUSE 1
`define MRF_RXS_CRC 0
`define MRF_RXS_PAUSE 1
`define MRF_RXS_CNT_LSB 16
`define MRF_MDC_REG_LSB 16
`define MRF_MDC_PHY_LSB 21
`define MRF_MDC_READ 26
`define MRF_MDS_BUSY 16
// reset values
`define MRF_RX_EN_RST 1'b0
`define MRF_CAM_EN_RST 32'h0000_0000
// receive framing
`define MRF_PRE_NIB 4'h5
`define MRF_SFD_NIB 4'hD
`define MRF_PRE_MAX 5'h0F
`define MRF_DA_LAST 11'h005
`define MRF_PAUSE_TYPE 16'h8808
`define MRF_PAUSE_OPCODE 16'h0001
`define MRF_PAUSE_LEN 11'h040
// timing: one pause quantum is 512 bit times at 100 Mb/s
`define MRF_CLK_NS 10
`define MRF_QUANTUM_NS 5120
`define MRF_QUANTUM_CYC ((`MRF_QUANTUM_NS + `MRF_CLK_NS - 1) / `MRF_CLK_NS)
`define MRF_MDC_HALF_NS 200
`define MRF_MDC_HALF_CYC (`MRF_MDC_HALF_NS / `MRF_CLK_NS)
// management frame layout
`define MRF_MD_PRE 32'hFFFF_FFFF
`define MRF_MD_START 2'b01
`define MRF_MD_OP_WR 2'b01
`define MRF_MD_OP_RD 2'b10
`define MRF_MD_TA_WR 2'b10
`define MRF_MD_LAST 6'h3F
`define MRF_MD_DRV_RD 6'h2E
`define MRF_MD_DATA_FIRST 6'h30
// bus answers
`define MRF_RESP_OKAY 2'b00
`define MRF_RESP_SLVERR 2'b10
`endif

// File: hw/mrf_pkg.sv
// types shared by the receive filter, management and pause block
package mrf_pkg;
   typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_DATA, RX_DROP} mrf_rx_state_t;
   typedef enum logic {MD_IDLE, MD_SHIFT} mrf_md_state_t;
   typedef logic [47:0] mrf_mac_t;
endpackage : mrf_pkg

// File: hw/mrf_mdio.sv
// station manager: builds management frames on mdc / mdio
`timescale 1ns/1ps
`include "mrf_params.svh"
module mrf_mdio import mrf_pkg::*; #(
   parameter int MDC_HALF = `MRF_MDC_HALF_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // command side
   input wire logic start,
   input wire logic rd_op,
   input wire logic [4:0] phy_addr,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] wdata,
   output logic busy,
   output logic [15:0] rdata,
   // management pins
   output logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_n
);
   mrf_md_state_t st_ff, nxt_st;
   logic [63:0] sh_ff, nxt_sh;
   logic [5:0] bit_ff, nxt_bit;
   logic [15:0] div_ff, nxt_div;
   logic mdc_ff, nxt_mdc;
   logic rd_ff, nxt_rd;
   logic [15:0] rdata_ff, nxt_rdata;
   logic md_s1_ff, md_s2_ff;
   logic half;

   // mdio input synchroniser, first stage feeds only the second
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         md_s1_ff <= 1'b0;
         md_s2_ff <= 1'b0;
      end else begin
         md_s1_ff <= mdio_i;
         md_s2_ff <= md_s1_ff;
      end
   end

   assign half = (div_ff == 16'(MDC_HALF - 1));

   // frame sequencer: bits change after mdc falls, phy samples on the rise
   always_comb begin
      nxt_st = st_ff;
      nxt_sh = sh_ff;
      nxt_bit = bit_ff;
      nxt_div = div_ff;
      nxt_mdc = mdc_ff;
      nxt_rd = rd_ff;
      nxt_rdata = rdata_ff;
      unique case (st_ff)
         MD_IDLE: begin
            if (start) begin
               nxt_st = MD_SHIFT;
               nxt_rd = rd_op;
               nxt_sh = {`MRF_MD_PRE, `MRF_MD_START,
                  rd_op ? `MRF_MD_OP_RD : `MRF_MD_OP_WR, phy_addr, reg_addr,
                  rd_op ? 2'b00 : `MRF_MD_TA_WR, rd_op ? 16'h0000 : wdata};
               nxt_bit = 6'h00;
               nxt_div = 16'h0000;
               nxt_mdc = 1'b0;
            end
         end
         MD_SHIFT: begin
            nxt_div = half ? 16'h0000 : div_ff + 16'h0001;
            if (half) begin
               nxt_mdc = ~mdc_ff;
               if (!mdc_ff) begin
                  // rising edge: phy data is stable, take it msb first
                  if (rd_ff && bit_ff >= `MRF_MD_DATA_FIRST) begin
                     nxt_rdata = {rdata_ff[14:0], md_s2_ff};
                  end
               end else if (bit_ff == `MRF_MD_LAST) begin
                  nxt_st = MD_IDLE;
               end else begin
                  nxt_bit = bit_ff + 6'h01;
                  nxt_sh = {sh_ff[62:0], 1'b0};
               end
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= MD_IDLE;
         sh_ff <= 64'h0;
         bit_ff <= 6'h00;
         div_ff <= 16'h0000;
         mdc_ff <= 1'b0;
         rd_ff <= 1'b0;
         rdata_ff <= 16'h0000;
      end else begin
         st_ff <= nxt_st;
         sh_ff <= nxt_sh;
         bit_ff <= nxt_bit;
         div_ff <= nxt_div;
         mdc_ff <= nxt_mdc;
         rd_ff <= nxt_rd;
         rdata_ff <= nxt_rdata;
      end
   end

   // a read releases the line from the turnaround on; idle is released
   assign mdio_oe_n = !(st_ff == MD_SHIFT && (!rd_ff || bit_ff < `MRF_MD_DRV_RD));
   assign mdio_o = sh_ff[63];
   assign mdc = mdc_ff;
   assign busy = (st_ff != MD_IDLE);
   assign rdata = rdata_ff;
endmodule : mrf_mdio

// File: hw/mrf_top.sv
// receive filter, station manager and full-duplex pause logic with axi4-lite registers
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "mrf_params.svh"
module mrf_top import mrf_pkg::*; #(
   parameter int NCAM = 21,
   parameter int FIFO_DEPTH = 16,
   parameter int QUANTUM = `MRF_QUANTUM_CYC,
   parameter int MDC_HALF = `MRF_MDC_HALF_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // axi4-lite slave
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // mii receive pins
   input wire logic rx_clk,
   input wire logic rx_dv,
   input wire logic rx_er,
   input wire logic [3:0] rxd,
   // receive fifo toward the dma engine
   input wire logic rx_rd,
   output logic [7:0] rx_db,
   output logic rx_rdy,
   output logic rx_toss,
   // pause toward transmitter and dma engine
   output logic tx_pause_halt,
   output logic pause_start,
   output logic pause_end,
   // remote pause frame
   output logic send_pause_request,
   output mrf_mac_t pause_da,
   output mrf_mac_t pause_sa,
   output mrf_mac_t pause_tlv,
   input wire logic ctl_tx_done,
   input wire logic [15:0] ctl_tx_status,
   // management pins
   output logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_n
);
   localparam int PW = $clog2(FIFO_DEPTH);

   // nibble of an address entry in wire order: low nibble of each byte first
   function automatic logic [3:0] cam_nib(input mrf_mac_t ent, input logic [3:0] idx);
      logic [47:0] sh;
      sh = ent >> (6'd40 - {idx[3:1], 3'b000});
      return idx[0] ? sh[7:4] : sh[3:0];
   endfunction : cam_nib

   function automatic logic is_cam(input logic [11:0] a);
      return a >= `MRF_OFF_CAM_BASE && a < 12'(`MRF_OFF_CAM_BASE + 8 * NCAM);
   endfunction : is_cam

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[8*b +: 8] = n[8*b +: 8];
      end
      return r;
   endfunction : merge

   // ---------------- mii input synchronisers ----------------
   logic [6:0] s1_ff, s2_ff;
   logic ck3_ff;
   logic nib_tick, dv_s, er_s;
   logic [3:0] nib_s;

   // two flops per pin and a third on rx_clk; the edge finder reads the second and third stages
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff <= 7'h00;
         s2_ff <= 7'h00;
         ck3_ff <= 1'b0;
      end else begin
         s1_ff <= {rx_clk, rx_dv, rx_er, rxd};
         s2_ff <= s1_ff;
         ck3_ff <= s2_ff[6];
      end
   end

   // sample on the falling link clock, half a period away from data changes
   assign nib_tick = ck3_ff & ~s2_ff[6];
   assign dv_s = s2_ff[5];
   assign er_s = s2_ff[4];
   assign nib_s = s2_ff[3:0];

   // ---------------- registers ----------------
   logic rx_en_ff, crc_ff, nxt_crc;
   logic [31:0] cam_en_ff;
   mrf_mac_t cam_ff [NCAM];
   logic [15:0] ctl_stat_ff;
   logic [15:0] pcnt_ff;
   logic md_busy;
   logic [15:0] md_rdata;

   // ---------------- receive parser ----------------
   mrf_rx_state_t st_ff, nxt_st;
   logic [10:0] bcnt_ff, nxt_bcnt;
   logic odd_ff, nxt_odd;
   logic [3:0] lo_ff, nxt_lo;
   logic [4:0] pre_ff, nxt_pre;
   logic [NCAM-1:0] mt_ff, nxt_mt;
   logic [15:0] typ_ff, nxt_typ, op_ff, nxt_op, opd_ff, nxt_opd;
   logic push, toss, pause_hit;
   logic [7:0] byte_in;

   // frames are assembled low nibble first; filter verdict on the 12th nibble
   always_comb begin
      nxt_st = st_ff;
      nxt_bcnt = bcnt_ff;
      nxt_odd = odd_ff;
      nxt_lo = lo_ff;
      nxt_pre = pre_ff;
      nxt_mt = mt_ff;
      nxt_typ = typ_ff;
      nxt_op = op_ff;
      nxt_opd = opd_ff;
      push = 1'b0;
      toss = 1'b0;
      pause_hit = 1'b0;
      byte_in = {nib_s, lo_ff};
      if (nib_tick || !dv_s) begin
         unique case (st_ff)
            RX_IDLE: begin
               if (rx_en_ff && dv_s && nib_s == `MRF_PRE_NIB) begin
                  nxt_st = RX_PRE;
                  nxt_pre = 5'h01;
               end
            end
            RX_PRE: begin
               if (!dv_s) begin
                  nxt_st = RX_IDLE;
               end else if (nib_s == `MRF_SFD_NIB) begin
                  nxt_st = RX_DATA;
                  nxt_bcnt = 11'h000;
                  nxt_odd = 1'b0;
                  nxt_mt = cam_en_ff[NCAM-1:0];
               end else if (nib_s != `MRF_PRE_NIB || pre_ff == `MRF_PRE_MAX) begin
                  nxt_st = RX_DROP; // no delimiter within eight bytes: fragment
               end else begin
                  nxt_pre = pre_ff + 5'h01;
               end
            end
            RX_DATA: begin
               if (!dv_s) begin
                  nxt_st = RX_IDLE;
                  pause_hit = !odd_ff && bcnt_ff == `MRF_PAUSE_LEN
                     && typ_ff == `MRF_PAUSE_TYPE && op_ff == `MRF_PAUSE_OPCODE
                     && mt_ff != '0;
               end else begin
                  if (bcnt_ff <= `MRF_DA_LAST) begin
                     for (int i = 0; i < NCAM; i++) begin
                        if (nib_s != cam_nib(cam_ff[i], {bcnt_ff[2:0], odd_ff})) begin
                           nxt_mt[i] = 1'b0;
                        end
                     end
                  end
                  nxt_odd = ~odd_ff;
                  if (!odd_ff) begin
                     nxt_lo = nib_s;
                  end else begin
                     push = 1'b1;
                     if (bcnt_ff != 11'h7FF) nxt_bcnt = bcnt_ff + 11'h001;
                     if (bcnt_ff == 11'h00C) nxt_typ[15:8] = byte_in;
                     if (bcnt_ff == 11'h00D) nxt_typ[7:0] = byte_in;
                     if (bcnt_ff == 11'h00E) nxt_op[15:8] = byte_in;
                     if (bcnt_ff == 11'h00F) nxt_op[7:0] = byte_in;
                     if (bcnt_ff == 11'h010) nxt_opd[15:8] = byte_in;
                     if (bcnt_ff == 11'h011) nxt_opd[7:0] = byte_in;
                     if (bcnt_ff == `MRF_DA_LAST && nxt_mt == '0) begin
                        push = 1'b0;
                        toss = 1'b1;
                        nxt_st = RX_DROP;
                     end
                  end
               end
            end
            RX_DROP: begin
               if (!dv_s) nxt_st = RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= RX_IDLE;
         bcnt_ff <= 11'h000;
         odd_ff <= 1'b0;
         lo_ff <= 4'h0;
         pre_ff <= 5'h00;
         mt_ff <= '0;
         typ_ff <= 16'h0000;
         op_ff <= 16'h0000;
         opd_ff <= 16'h0000;
      end else begin
         st_ff <= nxt_st;
         bcnt_ff <= nxt_bcnt;
         odd_ff <= nxt_odd;
         lo_ff <= nxt_lo;
         pre_ff <= nxt_pre;
         mt_ff <= nxt_mt;
         typ_ff <= nxt_typ;
         op_ff <= nxt_op;
         opd_ff <= nxt_opd;
      end
   end

   // ---------------- receive fifo ----------------
   logic [7:0] mem [FIFO_DEPTH];
   logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [PW:0] cnt_ff, nxt_cnt, frm_ff, nxt_frm, drop;
   logic [7:0] db_ff, nxt_db;
   logic pop, wr;

   // the newest frm_ff bytes belong to the frame being received
   always_comb begin
      pop = rx_rd && cnt_ff != '0;
      wr = push && cnt_ff != (PW+1)'(FIFO_DEPTH);
      drop = frm_ff - (PW+1)'(pop && cnt_ff == frm_ff);
      nxt_wp = wp_ff + PW'(wr);
      nxt_rp = rp_ff + PW'(pop);
      nxt_db = pop ? mem[rp_ff] : db_ff;
      nxt_cnt = cnt_ff + (PW+1)'(wr) - (PW+1)'(pop);
      nxt_frm = (pop && cnt_ff == frm_ff && frm_ff != '0) ? frm_ff - (PW+1)'(1) : frm_ff;
      nxt_frm = nxt_frm + (PW+1)'(wr);
      if (toss) begin
         nxt_wp = wp_ff - drop[PW-1:0];
         nxt_cnt = cnt_ff - drop - (PW+1)'(pop);
         nxt_frm = '0;
      end else if (nib_tick && st_ff == RX_PRE && nib_s == `MRF_SFD_NIB) begin
         nxt_frm = '0;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wp_ff <= '0;
         rp_ff <= '0;
         cnt_ff <= '0;
         frm_ff <= '0;
         db_ff <= 8'h00;
      end else begin
         wp_ff <= nxt_wp;
         rp_ff <= nxt_rp;
         cnt_ff <= nxt_cnt;
         frm_ff <= nxt_frm;
         db_ff <= nxt_db;
      end
   end

   // storage has no reset; contents are only read below the count
   always_ff @(posedge mclk) begin
      if (wr) mem[wp_ff] <= byte_in;
   end

   assign rx_rdy = cnt_ff != '0;
   assign rx_db = db_ff;

   // ---------------- pause counter ----------------
   logic [15:0] nxt_pcnt;
   logic [15:0] qt_ff, nxt_qt;
   logic ps_ff, nxt_ps, pe_ff, nxt_pe;

   // a reload restarts the quantum so every quantum is full length
   always_comb begin
      nxt_pcnt = pcnt_ff;
      nxt_qt = qt_ff;
      nxt_ps = 1'b0;
      nxt_pe = 1'b0;
      if (pause_hit) begin
         nxt_pcnt = opd_ff;
         nxt_qt = 16'h0000;
         nxt_ps = 1'b1;
         nxt_pe = pcnt_ff != 16'h0000 && opd_ff == 16'h0000;
      end else if (pcnt_ff != 16'h0000) begin
         nxt_qt = qt_ff + 16'h0001;
         if (qt_ff == 16'(QUANTUM - 1)) begin
            nxt_qt = 16'h0000;
            nxt_pcnt = pcnt_ff - 16'h0001;
            nxt_pe = pcnt_ff == 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pcnt_ff <= 16'h0000;
         qt_ff <= 16'h0000;
         ps_ff <= 1'b0;
         pe_ff <= 1'b0;
      end else begin
         pcnt_ff <= nxt_pcnt;
         qt_ff <= nxt_qt;
         ps_ff <= nxt_ps;
         pe_ff <= nxt_pe;
      end
   end

   assign tx_pause_halt = pcnt_ff != 16'h0000;
   assign pause_start = ps_ff;
   assign pause_end = pe_ff;

   // ---------------- axi4-lite slave ----------------
   logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
   logic [11:0] wa_ff, nxt_wa;
   logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rdv;
   logic [3:0] ws_ff, nxt_ws;
   logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
   logic wfire, sp_ff, nxt_sp, md_start;
   logic [4:0] cidx;
   logic [11:0] coff;

   // address and data are taken in either order; the write lands once both are held
   always_comb begin
      wfire = aw_ff && w_ff && !bv_ff;
      nxt_aw = wfire ? 1'b0 : aw_ff | (s_axi_awvalid & s_axi_awready);
      nxt_w = wfire ? 1'b0 : w_ff | (s_axi_wvalid & s_axi_wready);
      nxt_wa = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wa_ff;
      nxt_wd = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wd_ff;
      nxt_ws = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : ws_ff;
      nxt_bv = wfire | (bv_ff & ~s_axi_bready);
      nxt_br = br_ff;
      if (wfire) begin
         nxt_br = (is_cam(wa_ff) || wa_ff <= `MRF_OFF_CTL_TX) && wa_ff[1:0] == 2'b00 ?
            `MRF_RESP_OKAY : `MRF_RESP_SLVERR;
      end
      nxt_sp = wfire && wa_ff == `MRF_OFF_CTRL && ws_ff[0] && wd_ff[`MRF_CTRL_SEND_PAUSE];
      md_start = wfire && wa_ff == `MRF_OFF_MD_CMD && !md_busy;
      nxt_crc = crc_ff;
      if (wfire && wa_ff == `MRF_OFF_RX_STAT && ws_ff[0] && wd_ff[`MRF_RXS_CRC]) begin
         nxt_crc = 1'b0;
      end
      if (dv_s && er_s) nxt_crc = 1'b1;
      // read side
      nxt_rv = rv_ff & ~s_axi_rready;
      nxt_rdv = rd_ff;
      nxt_rr = rr_ff;
      coff = s_axi_araddr - `MRF_OFF_CAM_BASE;
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_rv = 1'b1;
         nxt_rr = `MRF_RESP_OKAY;
         nxt_rdv = 32'h0000_0000;
         if (is_cam(s_axi_araddr)) begin
            nxt_rdv = coff[2] ? {16'h0000, cam_ff[coff[7:3]][15:0]}
               : cam_ff[coff[7:3]][47:16];
         end else begin
            unique case (s_axi_araddr)
               `MRF_OFF_CTRL: nxt_rdv[`MRF_CTRL_RX_EN] = rx_en_ff;
               `MRF_OFF_RX_STAT: nxt_rdv = {pcnt_ff, 14'h0000, tx_pause_halt, crc_ff};
               `MRF_OFF_CAM_EN: nxt_rdv[NCAM-1:0] = cam_en_ff[NCAM-1:0];
               `MRF_OFF_MD_STAT: nxt_rdv = {15'h0000, md_busy, md_rdata};
               `MRF_OFF_CTL_TX: nxt_rdv = {16'h0000, ctl_stat_ff};
               default: nxt_rr = `MRF_RESP_SLVERR;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         bv_ff <= 1'b0;
         rv_ff <= 1'b0;
         wa_ff <= 12'h000;
         wd_ff <= 32'h0000_0000;
         ws_ff <= 4'h0;
         br_ff <= `MRF_RESP_OKAY;
         rr_ff <= `MRF_RESP_OKAY;
         rd_ff <= 32'h0000_0000;
         sp_ff <= 1'b0;
         crc_ff <= 1'b0;
      end else begin
         aw_ff <= nxt_aw;
         w_ff <= nxt_w;
         bv_ff <= nxt_bv;
         rv_ff <= nxt_rv;
         wa_ff <= nxt_wa;
         wd_ff <= nxt_wd;
         ws_ff <= nxt_ws;
         br_ff <= nxt_br;
         rr_ff <= nxt_rr;
         rd_ff <= nxt_rdv;
         sp_ff <= nxt_sp;
         crc_ff <= nxt_crc;
      end
   end

   // software-written state: receive enable, entry enables, entries; control status loads from ctl_tx_status
   function automatic logic [11:0] coff_w(input logic [11:0] a);
      return a - `MRF_OFF_CAM_BASE;
   endfunction : coff_w
   assign cidx = 5'(coff_w(wa_ff) >> 3);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_en_ff <= `MRF_RX_EN_RST;
         cam_en_ff <= `MRF_CAM_EN_RST;
         ctl_stat_ff <= 16'h0000;
         for (int i = 0; i < NCAM; i++) cam_ff[i] <= 48'h0;
      end else begin
         if (wfire && wa_ff == `MRF_OFF_CTRL && ws_ff[0]) rx_en_ff <= wd_ff[`MRF_CTRL_RX_EN];
         if (wfire && wa_ff == `MRF_OFF_CAM_EN) cam_en_ff <= merge(cam_en_ff, wd_ff, ws_ff);
         if (wfire && is_cam(wa_ff) && !wa_ff[2]) begin
            cam_ff[cidx][47:16] <= merge(cam_ff[cidx][47:16], wd_ff, ws_ff);
         end
         if (wfire && is_cam(wa_ff) && wa_ff[2]) begin
            cam_ff[cidx][15:0] <= 16'(merge({16'h0000, cam_ff[cidx][15:0]}, wd_ff, ws_ff));
         end
         if (ctl_tx_done) ctl_stat_ff <= ctl_tx_status;
      end
   end

   assign s_axi_awready = !aw_ff && !bv_ff;
   assign s_axi_wready = !w_ff && !bv_ff;
   assign s_axi_bvalid = bv_ff;
   assign s_axi_bresp = br_ff;
   assign s_axi_arready = !rv_ff;
   assign s_axi_rvalid = rv_ff;
   assign s_axi_rdata = rd_ff;
   assign s_axi_rresp = rr_ff;
   assign rx_toss = toss;
   assign send_pause_request = sp_ff;
   // entries 0, 1 and 18 hold the prepared pause frame header
   assign pause_da = cam_ff[0];
   assign pause_sa = cam_ff[1];
   assign pause_tlv = cam_ff[18];

   // ---------------- station manager ----------------
   mrf_mdio #(.MDC_HALF(MDC_HALF)) u_mdio (
      .mclk(mclk),
      .reset_n(reset_n),
      .start(md_start),
      .rd_op(wd_ff[`MRF_MDC_READ]),
      .phy_addr(wd_ff[`MRF_MDC_PHY_LSB +: 5]),
      .reg_addr(wd_ff[`MRF_MDC_REG_LSB +: 5]),
      .wdata(wd_ff[15:0]),
      .busy(md_busy),
      .rdata(md_rdata),
      .mdc(mdc),
      .mdio_i(mdio_i),
      .mdio_o(mdio_o),
      .mdio_oe_n(mdio_oe_n)
   );
endmodule : mrf_top

// File: test/mrf_top_asserts.sv
// port assertions for the filter, management and pause block
`timescale 1ns/1ps
module mrf_top_asserts (
   // watched ports
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic rx_toss,
   input wire logic pause_start,
   input wire logic pause_end,
   input wire logic tx_pause_halt,
   input wire logic send_pause_request,
   input wire logic mdc
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // high phase of mdc for the bench value MDC_HALF = 4
   sequence mdc_hi; mdc [*4]; endsequence
   a_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid");
   a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("awready");
   a_toss_pulse: assert property (rx_toss |=> !rx_toss) else $error("toss");
   a_start_once: assert property (pause_start |=> !pause_start) else $error("start");
   a_end_clear: assert property (pause_end |-> !tx_pause_halt) else $error("end");
   a_halt_end: assert property ($fell(tx_pause_halt) |-> pause_end) else $error("halt");
   a_req_pulse: assert property (send_pause_request |=> !send_pause_request) else $error("req");
   a_mdc_half: assert property ($rose(mdc) |-> mdc_hi ##1 !mdc) else $error("mdc");
endmodule : mrf_top_asserts

// File: test/mrf_phy_model.sv
// phy model: mdio responder that records each 64-bit management frame
`timescale 1ns/1ps
module mrf_phy_model #(parameter logic [15:0] RD_VAL = 16'hA5C3) (
   // management pins
   input wire logic mdc,
   input wire logic mdio,
   output logic drv = 1'b0,
   output logic val = 1'b0,
   output logic [63:0] frm = '0
);
   logic [63:0] sh = '0;
   logic [5:0] n = '0;
   logic rd = 1'b0;
   // sample on mdc rise, msb first; the op code picks a read
   always @(posedge mdc) begin
      sh <= {sh[62:0], mdio};
      n <= n + 6'h01;
      if (n == 6'h23) rd <= sh[0] & ~mdio;
      if (n == 6'h3F) frm <= {sh[62:0], mdio};
   end
   // turnaround zero then data, changed after mdc falls; released line reads 1
   always @(negedge mdc) begin
      drv <= rd && n >= 6'h2F;
      val <= n != 6'h2F && RD_VAL[4'(6'h3F - n)];
   end
endmodule : mrf_phy_model

// File: test/mrf_top_test.sv
// testbench for the filter, management and pause block
`timescale 1ns/1ps
`include "mrf_params.svh"
module mrf_top_test;
   import mrf_pkg::*;
   localparam mrf_mac_t DA = 48'h0180_C200_0001;
   logic mclk = 1'b0, reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1, rx_rd = 1'b0;
   logic rx_clk = 1'b0, rx_dv = 1'b0, rx_er = 1'b0, ctl_tx_done = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
   logic [15:0] ctl_tx_status = '0;
   logic [3:0] s_axi_wstrb = 4'hF, rxd = 4'h0;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [7:0] rx_db, fb [64];
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_rdy, rx_toss;
   logic tx_pause_halt, pause_start, pause_end, send_pause_request, mdc, mdio_o, mdio_oe_n;
   logic drv, val, ts = 1'b0, ps = 1'b0, pe = 1'b0, sp = 1'b0;
   logic [63:0] frm;
   mrf_mac_t pause_da, pause_sa, pause_tlv;
   int error_cnt = 0, checked = 0, cyc = 0;
   wire mdio_i = !mdio_oe_n ? mdio_o : drv ? val : 1'b1;
   mrf_top #(.QUANTUM(4), .MDC_HALF(4)) mrf_top_i (.*);
   mrf_phy_model mrf_phy_model_i (.mdc(mdc), .mdio(mdio_i), .drv(drv), .val(val), .frm(frm));
   always #5 mclk = ~mclk;
   // sticky event flags and the hang limit
   always @(posedge mclk) begin
      ts <= ts | rx_toss;
      ps <= ps | pause_start;
      pe <= pe | pause_end;
      sp <= sp | send_pause_request;
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         error_cnt++;
         summarize();
      end
   end
   task summarize();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   task chk(input logic [63:0] s, e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch at %0t: %h vs %h", $time, s, e);
      end
   endtask : chk
   // both write halves offered together; bready stays high
   task wr(input logic [11:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
      do @(negedge mclk); while (!(s_axi_awready && s_axi_wready));
      @(posedge mclk);
      {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
      do @(negedge mclk); while (!s_axi_bvalid);
      chk(s_axi_bresp, `MRF_RESP_OKAY);
      @(posedge mclk);
   endtask : wr
   task rd(input logic [11:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge mclk); while (!s_axi_arready);
      @(posedge mclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge mclk); while (!s_axi_rvalid);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge mclk);
   endtask : rd
   // rx_clk runs only inside frames, data low nibble first
   task frame(input int nb, input int er);
      @(posedge mclk);
      for (int i = 0; i < 16 + 2 * nb; i++) begin
         rx_clk <= 1'b1;
         rx_dv <= 1'b1;
         rxd <= i < 15 ? 4'h5 : i == 15 ? 4'hD : i % 2 ? fb[i/2-8][7:4] : fb[i/2-8][3:0];
         rx_er <= i == er;
         #80 rx_clk <= 1'b0;
         #80;
      end
      rx_dv <= 1'b0;
      rxd <= ~rxd;
      rx_er <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : frame
   task pframe(input logic [15:0] op);
      foreach (fb[i]) fb[i] = 8'h00;
      {fb[0], fb[1], fb[2], fb[3], fb[4], fb[5]} = DA;
      {fb[12], fb[13], fb[14], fb[15], fb[16], fb[17]} = {`MRF_PAUSE_TYPE, `MRF_PAUSE_OPCODE, op};
      frame(64, -1);
   endtask : pframe
   initial begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      rd(`MRF_OFF_CAM_EN);
      chk(rv, `MRF_CAM_EN_RST);
      rd(12'h0F0);
      chk(rr, `MRF_RESP_SLVERR);
      // management write then read; frames compared as seen on the wire
      for (int op = 0; op < 2; op++) begin
         wr(`MRF_OFF_MD_CMD, {5'h00, op[0], 5'h11, 5'h0A, 16'h1234});
         do rd(`MRF_OFF_MD_STAT); while (rv[`MRF_MDS_BUSY] !== 1'b0);
         chk(frm, {`MRF_MD_PRE, `MRF_MD_START, op[0] ? `MRF_MD_OP_RD : `MRF_MD_OP_WR, 5'h11,
            5'h0A, `MRF_MD_TA_WR, op[0] ? 16'hA5C3 : 16'h1234});
         if (op == 1) chk(rv[15:0], 16'hA5C3);
      end
      // no entry enabled: error nibble inside a rejected frame
      wr(`MRF_OFF_CTRL, 32'h1);
      foreach (fb[i]) fb[i] = 8'(i);
      frame(14, 20);
      chk(ts, 1'b1);
      chk(rx_rdy, 1'b0);
      rd(`MRF_OFF_RX_STAT);
      chk(rv[`MRF_RXS_CRC], 1'b1);
      wr(`MRF_OFF_RX_STAT, 32'h1);
      rd(`MRF_OFF_RX_STAT);
      chk(rv[`MRF_RXS_CRC], 1'b0);
      // long pause, then a zero operand ends it early
      rx_rd <= 1'b1;
      wr(12'h100, DA[47:16]);
      wr(12'h104, {16'h0000, DA[15:0]});
      wr(`MRF_OFF_CAM_EN, 32'h1);
      pframe(16'h0400);
      chk({ps, pe, tx_pause_halt}, 3'b101);
      pframe(16'h0000);
      chk({pe, tx_pause_halt}, 2'b10);
      wr(`MRF_OFF_CTRL, 32'h3);
      ctl_tx_status <= 16'h5A5A;
      ctl_tx_done <= 1'b1;
      @(posedge mclk);
      ctl_tx_done <= 1'b0;
      rd(`MRF_OFF_CTL_TX);
      chk(rv[15:0], 16'h5A5A);
      chk({sp, pause_da}, {1'b1, DA});
      summarize();
   end
endmodule : mrf_top_test
bind mrf_top mrf_top_asserts mrf_top_asserts_i (.*);
